// ==== hdl/slave_fifo_defs.vh ====
// constants for the slave fifo host port
`ifndef SLAVE_FIFO_DEFS_VH
`define SLAVE_FIFO_DEFS_VH

// ****************************************
// widths and depths
// ****************************************
`define SFP_DATA_W 32
`define SFP_ADDR_W 5
`define SFP_SOCK_W 2
`define SFP_DEPTH 16
`define SFP_PART_LVL 8
`define SFP_PROD_MASK 4'h5

// ****************************************
// flag modes
// ****************************************
`define SFP_FLAG_EMPTY 2'h0
`define SFP_FLAG_FULL 2'h1
`define SFP_FLAG_PART 2'h2

// ****************************************
// timing counts, in interface clock cycles
// ****************************************
`define SFP_RD_LAT 2
`define SFP_FLAG_LAT 3
`define SFP_ADDR_LAT 3
`define SFP_SSD_MIN 2
`define SFP_SSD_MAX 68
`define SFP_SSD_W 7
// address width of the variant that has a switching delay
`define SFP_SSD_ADDR_W 5

`endif

// ==== hdl/sock_fifo.v ====
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
module sock_fifo #(
	parameter W = 32,
	parameter DEPTH = 16,
	parameter PW = 4
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	// fill side
	input wire i_valid,
	output wire o_ready,
	input wire [W-1:0] i_data,
	// drain side
	output wire o_valid,
	input wire i_ready,
	output wire [W-1:0] o_data,
	output wire [PW:0] o_count
);

reg [W-1:0] mem_r [0:DEPTH-1];
reg [PW-1:0] wp_r;
reg [PW-1:0] rp_r;
reg [PW:0] cnt_r;
wire push = i_valid & o_ready;
wire pop = i_ready & o_valid;

assign o_ready = (cnt_r != DEPTH[PW:0]);
assign o_valid = (cnt_r != {(PW+1){1'b0}});
assign o_data = mem_r[rp_r];
assign o_count = cnt_r;

// storage has no reset; only pointers and count need a defined value
always @(posedge i_clk) begin
	if (push) begin
		mem_r[wp_r] <= i_data;
	end
end

// pointers wrap by index, count tracks occupancy
always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		wp_r <= {PW{1'b0}};
		rp_r <= {PW{1'b0}};
		cnt_r <= {(PW+1){1'b0}};
	end else begin
		if (push) begin
			wp_r <= (wp_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : wp_r + 1'b1;
		end
		if (pop) begin
			rp_r <= (rp_r == DEPTH[PW-1:0] - 1'b1) ? {PW{1'b0}} : rp_r + 1'b1;
		end
		if (push & ~pop) begin
			cnt_r <= cnt_r + 1'b1;
		end else if (pop & ~push) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
end

endmodule // sock_fifo

// ==== hdl/slave_fifo_port.v ====
// device side of the slave fifo host port
`timescale 1ns/100ps
`include "slave_fifo_defs.vh"
module slave_fifo_port #(
	parameter DW = `SFP_DATA_W,
	parameter AW = `SFP_ADDR_W,
	parameter SW = `SFP_SOCK_W,
	parameter DEPTH = `SFP_DEPTH,
	parameter PART_LVL = `SFP_PART_LVL,
	parameter PROD_MASK = `SFP_PROD_MASK,
	parameter SSD_CYC = `SFP_SSD_MIN
) (
	// clock and reset
	input wire I_MCLK,
	input wire I_NRST,
	// link clock and mode strap
	input wire I_IF_CLK,
	input wire I_ASYNC_MODE,
	// host control strobes, active low
	input wire I_PORT_CHIP_SELECT_N,
	input wire I_BUS_OUTPUT_ENABLE_N,
	input wire I_READ_STROBE_N,
	input wire I_WRITE_STROBE_N,
	input wire I_PACKET_END_N,
	input wire I_SOCKET_SWITCH_N,
	// address and data bus
	input wire [AW-1:0] I_ADDR,
	input wire [DW-1:0] I_DQ,
	output wire [DW-1:0] O_DQ,
	output wire O_DQ_OE,
	// flag configuration
	input wire [1:0] I_FLAG_A_MODE,
	input wire I_FLAG_A_CUR,
	input wire [SW-1:0] I_FLAG_A_SOCK,
	input wire [1:0] I_FLAG_B_MODE,
	input wire I_FLAG_B_CUR,
	input wire [SW-1:0] I_FLAG_B_SOCK,
	// status flags
	output wire O_FLAG_A,
	output wire O_FLAG_B,
	output wire O_THREAD_READY
);

localparam NS = 1 << SW;
localparam PW = $clog2(DEPTH);
localparam CW = PW + 1;
localparam FW = 2 + 1 + SW;
localparam SV = 9 + AW + DW + 2 * FW;
localparam SSD_EN = (AW == `SFP_SSD_ADDR_W);

// ****************************************
// reset release and pin synchronisers
// ****************************************

reg [1:0] rst_sync_r;
wire rst_n = rst_sync_r[1];

// reset enters asynchronously, leaves through two flops
always @(posedge I_MCLK or negedge I_NRST) begin
	if (!I_NRST) begin
		rst_sync_r <= 2'b00;
	end else begin
		rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
end

wire [SV-1:0] pins = {I_IF_CLK, I_ASYNC_MODE, I_PORT_CHIP_SELECT_N,
	I_BUS_OUTPUT_ENABLE_N, I_READ_STROBE_N, I_WRITE_STROBE_N,
	I_PACKET_END_N, I_SOCKET_SWITCH_N, 1'b0, I_ADDR, I_DQ,
	I_FLAG_A_MODE, I_FLAG_A_CUR, I_FLAG_A_SOCK,
	I_FLAG_B_MODE, I_FLAG_B_CUR, I_FLAG_B_SOCK};
// strobes come out of reset at their idle high level, so no false edge
localparam [SV-1:0] PIN_IDLE = {2'h0, 6'h3f, {(SV-8){1'b0}}};
reg [SV-1:0] meta_r;
reg [SV-1:0] pin_r;

// every pin, data included, sees the same two-flop delay
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		meta_r <= PIN_IDLE;
		pin_r <= PIN_IDLE;
	end else begin
		meta_r <= pins;
		pin_r <= meta_r;
	end
end

wire if_clk_s = pin_r[SV-1];
wire async_m = pin_r[SV-2];
wire cs = ~pin_r[SV-3];
wire oe = ~pin_r[SV-4];
wire rd = ~pin_r[SV-5];
wire wr = ~pin_r[SV-6];
wire pe = ~pin_r[SV-7];
wire sw = ~pin_r[SV-8];
wire [AW-1:0] pin_addr = pin_r[2*FW+DW +: AW];
wire [DW-1:0] pin_dq = pin_r[2*FW +: DW];
wire [FW-1:0] cfg_a = pin_r[FW +: FW];
wire [FW-1:0] cfg_b = pin_r[0 +: FW];
wire [SW-1:0] ev_sock = pin_addr[SW-1:0];

// ****************************************
// event detection
// ****************************************

reg if_clk_d_r;
reg rd_d_r;
reg wr_d_r;
reg pe_d_r;
reg sw_d_r;

// previous samples for edge finding on synchronised copies
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		if_clk_d_r <= 1'b0;
		rd_d_r <= 1'b0;
		wr_d_r <= 1'b0;
		pe_d_r <= 1'b0;
		sw_d_r <= 1'b0;
	end else begin
		if_clk_d_r <= if_clk_s;
		rd_d_r <= rd;
		wr_d_r <= wr;
		pe_d_r <= pe;
		sw_d_r <= sw;
	end
end

// tick marks a rising link clock edge; the master samples there too
wire tick = if_clk_s & ~if_clk_d_r;
wire s_ev = ~async_m & tick & cs;
// async strobes are edges; read acts at both ends of its pulse
wire a_rd_fall = async_m & cs & rd & ~rd_d_r;
wire a_rd_rise = async_m & cs & ~rd & rd_d_r;
wire a_wr_rise = async_m & cs & ~wr & wr_d_r;
wire a_pe_fall = async_m & cs & pe & ~pe_d_r;
wire a_sw_fall = async_m & cs & sw & ~sw_d_r;
// unit of delay counting differs per mode: link edges in sync, core clocks in async
wire unit = async_m | tick;

wire push_ev = (s_ev & wr) | a_wr_rise;
wire pop_ev = (s_ev & rd) | a_rd_rise;
wire pe_ev = (s_ev & pe) | a_pe_fall;
wire sw_ev = (s_ev & sw) | a_sw_fall;

// ****************************************
// socket buffers and packet commit
// ****************************************

wire [NS-1:0] f_rdy;
wire [NS-1:0] f_val;
wire [NS*DW-1:0] f_head;
wire [NS*CW-1:0] f_cnt;
wire [NS*CW-1:0] commit_v;
wire [CW-1:0] ev_commit = commit_v[ev_sock*CW +: CW];
// reads stop at the last committed word of the socket
wire pop_ok = pop_ev & f_val[ev_sock] & (ev_commit != {CW{1'b0}});

genvar g;
generate
	for (g = 0; g < NS; g = g + 1) begin : g_sock
		wire hit = (ev_sock == g);
		// push is refused while the buffer is full
		wire pushed = push_ev & hit & f_rdy[g];
		wire popped = pop_ok & hit;
		wire [CW-1:0] cnt = f_cnt[g*CW +: CW];
		reg [CW-1:0] commit_r;

		sock_fifo #(
			.W(DW),
			.DEPTH(DEPTH),
			.PW(PW)
		) u_fifo (
			.i_clk(I_MCLK),
			.i_rst_n(rst_n),
			.i_valid(push_ev & hit),
			.o_ready(f_rdy[g]),
			.i_data(pin_dq),
			.o_valid(f_val[g]),
			.i_ready(popped),
			.o_data(f_head[g*DW +: DW]),
			.o_count(f_cnt[g*CW +: CW])
		);

		// packet end turns every stored word into readable data
		always @(posedge I_MCLK or negedge rst_n) begin
			if (!rst_n) begin
				commit_r <= {CW{1'b0}};
			end else if (pe_ev & hit) begin
				commit_r <= cnt + {{(CW-1){1'b0}}, pushed}
					- {{(CW-1){1'b0}}, popped};
			end else if (popped) begin
				commit_r <= commit_r - 1'b1;
			end
		end
		assign commit_v[g*CW +: CW] = commit_r;
	end
endgenerate

// ****************************************
// read data path
// ****************************************

reg [DW-1:0] rd_p1_r;
reg [DW-1:0] rd_p2_r;
reg [DW-1:0] dq_r;
reg dq_oe_r;
wire [DW-1:0] ev_head = f_head[ev_sock*DW +: DW];

// sync reads go through two stages so data lands two edges later
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		rd_p1_r <= {DW{1'b0}};
		rd_p2_r <= {DW{1'b0}};
		dq_r <= {DW{1'b0}};
	end else if (async_m) begin
		if (a_rd_fall) begin
			dq_r <= ev_head;
		end
	end else if (tick) begin
		if (pop_ok) begin
			rd_p1_r <= ev_head;
		end
		rd_p2_r <= rd_p1_r;
		dq_r <= rd_p2_r;
	end
end

// enable touches only the drive; held word shows early
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		dq_oe_r <= 1'b0;
	end else begin
		dq_oe_r <= cs & oe;
	end
end

assign O_DQ = dq_r;
assign O_DQ_OE = dq_oe_r;

// ****************************************
// status flags
// ****************************************

reg [SW-1:0] addr_r;

// sync address is taken at link edges, async follows the pins
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		addr_r <= {SW{1'b0}};
	end else if (async_m | s_ev) begin
		addr_r <= ev_sock;
	end
end

// one decode shared by both flag outputs
function flag_eval;
	input [FW-1:0] cfg;
	input [SW-1:0] cur;
	input [NS*CW-1:0] cnts;
	reg [SW-1:0] s;
	reg [CW-1:0] c;
	begin
		s = cfg[SW] ? cur : cfg[SW-1:0];
		c = cnts[s*CW +: CW];
		case (cfg[FW-1:FW-2])
			`SFP_FLAG_EMPTY: flag_eval = (c == {CW{1'b0}});
			`SFP_FLAG_FULL: flag_eval = (c == DEPTH[CW-1:0]);
			`SFP_FLAG_PART: flag_eval = (c >= PART_LVL[CW-1:0]);
			default: flag_eval = 1'b0;
		endcase
	end
endfunction

wire [1:0] flag_c = {flag_eval(cfg_b, addr_r, f_cnt),
	flag_eval(cfg_a, addr_r, f_cnt)};
reg [1:0] fl_p1_r;
reg [1:0] fl_p2_r;
reg [1:0] flag_r;

// three link edges from write or address change to flag pins in sync mode, one core clock in async
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		fl_p1_r <= 2'b00;
		fl_p2_r <= 2'b00;
		flag_r <= 2'b00;
	end else if (async_m) begin
		flag_r <= flag_c;
	end else if (tick) begin
		fl_p1_r <= flag_c;
		fl_p2_r <= fl_p1_r;
		flag_r <= fl_p2_r;
	end
end

assign O_FLAG_A = flag_r[0];
assign O_FLAG_B = flag_r[1];

// ****************************************
// socket switching and thread ready
// ****************************************

reg [`SFP_SSD_W-1:0] ssd_r;
reg thr_rdy_r;
// producers need room, consumers need committed data
wire prod = PROD_MASK[addr_r];
wire rdy_c = prod ? f_rdy[addr_r]
	: (commit_v[addr_r*CW +: CW] != {CW{1'b0}});

// delay counted down in link edges or internal clocks
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		ssd_r <= {`SFP_SSD_W{1'b0}};
	end else if (sw_ev & SSD_EN) begin
		ssd_r <= SSD_CYC[`SFP_SSD_W-1:0];
	end else if (unit & (ssd_r != {`SFP_SSD_W{1'b0}})) begin
		ssd_r <= ssd_r - 1'b1;
	end
end

// ready is held off while a switch is still settling
always @(posedge I_MCLK or negedge rst_n) begin
	if (!rst_n) begin
		thr_rdy_r <= 1'b0;
	end else if (sw_ev & SSD_EN) begin
		thr_rdy_r <= 1'b0;
	end else begin
		thr_rdy_r <= rdy_c & (ssd_r == {`SFP_SSD_W{1'b0}});
	end
end

assign O_THREAD_READY = thr_rdy_r;

endmodule // slave_fifo_port

// ==== dv/slave_fifo_port_assertions.sv ====
// pin-level assertions for the slave fifo host port
`timescale 1ns/100ps
module slave_fifo_port_assertions #(
	parameter AW = 5,
	parameter DW = 32
) (
	input wire I_MCLK,
	input wire I_NRST,
	input wire I_ASYNC_MODE,
	input wire I_PORT_CHIP_SELECT_N,
	input wire I_BUS_OUTPUT_ENABLE_N,
	input wire I_READ_STROBE_N,
	input wire [AW-1:0] I_ADDR,
	input wire [DW-1:0] O_DQ,
	input wire O_DQ_OE,
	input wire [1:0] I_FLAG_A_MODE,
	input wire I_FLAG_A_CUR,
	input wire [1:0] I_FLAG_B_MODE,
	input wire I_FLAG_B_CUR,
	input wire O_FLAG_A,
	input wire O_FLAG_B
);
	// ****************************************
	// pin relations
	// ****************************************
	default clocking cb @(posedge I_MCLK); endclocking
	default disable iff (!I_NRST);
	// pins pass two sync flops and a register, so windows span 8 edges
	sequence s_bus_off;
		(I_BUS_OUTPUT_ENABLE_N || I_PORT_CHIP_SELECT_N) [*8];
	endsequence
	sequence s_bus_on;
		(!I_BUS_OUTPUT_ENABLE_N && !I_PORT_CHIP_SELECT_N) [*8];
	endsequence
	sequence s_async_quiet;
		(I_ASYNC_MODE && $stable(I_READ_STROBE_N) && $stable(I_ADDR)) [*8];
	endsequence
	// empty on a against full or partial on b, same current socket
	sequence s_same_pick;
		(I_FLAG_A_MODE == 2'h0 && I_FLAG_B_MODE != 2'h0 && I_FLAG_A_CUR
			&& I_FLAG_B_CUR && $stable(I_ADDR)) [*8];
	endsequence
	a_bus_off: assert property (s_bus_off |-> !O_DQ_OE)
		else $error("bus driven while disabled");
	a_bus_on: assert property (s_bus_on |-> O_DQ_OE)
		else $error("bus not driven while enabled");
	a_oe_drop: assert property ($rose(I_BUS_OUTPUT_ENABLE_N) |-> ##[1:4] !O_DQ_OE)
		else $error("bus kept after enable release");
	a_async_hold: assert property (s_async_quiet |-> $stable(O_DQ))
		else $error("async data moved without strobe edge");
	a_flag_a_never: assert property ((I_FLAG_A_MODE == 2'h3) [*5] |-> !O_FLAG_A)
		else $error("flag a set in off mode");
	a_flag_b_never: assert property ((I_FLAG_B_MODE == 2'h3) [*5] |-> !O_FLAG_B)
		else $error("flag b set in off mode");
	a_flags_exclusive: assert property (s_same_pick |-> !(O_FLAG_A && O_FLAG_B))
		else $error("empty and fill flags both set");
	a_reset_quiet: assert property (disable iff (1'b0) !I_NRST ##1 !I_NRST |-> !O_DQ_OE && !O_FLAG_A)
		else $error("outputs active in reset");
endmodule // slave_fifo_port_assertions
bind slave_fifo_port slave_fifo_port_assertions #(.AW(AW), .DW(DW))
	i_slave_fifo_port_assertions (.I_MCLK, .I_NRST, .I_ASYNC_MODE,
	.I_PORT_CHIP_SELECT_N, .I_BUS_OUTPUT_ENABLE_N, .I_READ_STROBE_N,
	.I_ADDR, .O_DQ, .O_DQ_OE, .I_FLAG_A_MODE, .I_FLAG_A_CUR,
	.I_FLAG_B_MODE, .I_FLAG_B_CUR, .O_FLAG_A, .O_FLAG_B);

// ==== dv/fifo_master_model.sv ====
// model of the external processor that masters the port
`timescale 1ns/100ps
module fifo_master_model (
	// core clock and device side of the bus
	input wire i_mclk,
	input wire [31:0] i_dq,
	input wire i_dq_oe,
	// master pins
	output logic o_ifclk,
	output logic [5:0] o_ctl,
	output logic [4:0] o_addr,
	output wire [31:0] o_dq
);
	// ****************************************
	// pin drivers
	// ****************************************
	logic [31:0] dq_r;
	logic drv_r;
	initial begin
		o_ifclk = 1'b0;
		o_ctl = 6'h3f;
		o_addr = 5'h00;
		dq_r = 32'h0;
		drv_r = 1'b0;
		// interface clock runs free, unrelated in phase to the core clock
		forever #62.5 o_ifclk = ~o_ifclk;
	end
	// released bus shows the flipped residue, never a tidy last value
	assign o_dq = i_dq_oe ? i_dq : (drv_r ? dq_r : ~dq_r);
	// step past an interface fall, then change on a core falling edge
	task tick;
		@(negedge o_ifclk);
		@(negedge i_mclk);
	endtask
	// pins hold until the next call, so address and select stay put
	task put(input [5:0] ctl, input [4:0] a, input [31:0] d, input drv);
		o_ctl = ctl;
		o_addr = a;
		dq_r = d;
		drv_r = drv;
	endtask
endmodule // fifo_master_model

// ==== dv/slave_fifo_port_tb.sv ====
// self-checking bench for the slave fifo host port
`timescale 1ns/100ps
module slave_fifo_port_tb;
	// ****************************************
	// signals, instances and helpers
	// ****************************************
	localparam logic [5:0] SEL = 6'h1f, WR = 6'h1b, WRPE = 6'h19;
	localparam logic [5:0] RD = 6'h07, OEON = 6'h0f, SW = 6'h1e, PE = 6'h1d;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic async_m = 1'b0;
	logic [1:0] a_mode = 2'h0;
	logic [1:0] b_mode = 2'h3;
	logic b_cur = 1'b0;
	int err_total = 0;
	int total_checks = 0;
	wire ifclk, dq_oe, fa, fb, trdy;
	wire [5:0] ctl;
	wire [4:0] addr;
	wire [31:0] dq, dq_out;
	always #5 mclk = ~mclk;
	fifo_master_model i_fifo_master_model (.i_mclk(mclk), .i_dq(dq_out),
		.i_dq_oe(dq_oe), .o_ifclk(ifclk), .o_ctl(ctl), .o_addr(addr),
		.o_dq(dq));
	slave_fifo_port i_slave_fifo_port (.I_MCLK(mclk), .I_NRST(nrst),
		.I_IF_CLK(ifclk), .I_ASYNC_MODE(async_m),
		.I_PORT_CHIP_SELECT_N(ctl[5]), .I_BUS_OUTPUT_ENABLE_N(ctl[4]),
		.I_READ_STROBE_N(ctl[3]), .I_WRITE_STROBE_N(ctl[2]),
		.I_PACKET_END_N(ctl[1]), .I_SOCKET_SWITCH_N(ctl[0]),
		.I_ADDR(addr), .I_DQ(dq), .O_DQ(dq_out), .O_DQ_OE(dq_oe),
		.I_FLAG_A_MODE(a_mode), .I_FLAG_A_CUR(1'b1), .I_FLAG_A_SOCK(2'h0),
		.I_FLAG_B_MODE(b_mode), .I_FLAG_B_CUR(b_cur), .I_FLAG_B_SOCK(2'h3),
		.O_FLAG_A(fa), .O_FLAG_B(fb), .O_THREAD_READY(trdy));
	task automatic tk(input int n);
		repeat (n) i_fifo_master_model.tick;
	endtask
	task automatic wc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic pt(input logic [5:0] c, input logic [4:0] a,
		input logic [31:0] d, input logic drv);
		i_fifo_master_model.put(c, a, d, drv);
	endtask
	task automatic check(input string what, input logic [31:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ****************************************
	// scenarios
	// ****************************************
	// one committed write moves the empty flag exactly three edges later
	task automatic t_write;
		tk(1);
		pt(WRPE, 5'h01, 32'ha000_0000, 1'b1);
		tk(1);
		pt(SEL, 5'h01, 32'h0, 1'b0);
		tk(2);
		check("flag early", fa, 1'b1);
		tk(1);
		check("flag on time", fa, 1'b0);
		pt(WR, 5'h01, 32'ha000_0001, 1'b1);
		tk(1);
		pt(WRPE, 5'h01, 32'ha000_0002, 1'b1);
		tk(1);
		pt(SEL, 5'h01, 32'h0, 1'b0);
	endtask
	// burst of three pops, each word two edges after its strobe edge
	task automatic t_read;
		int i;
		tk(1);
		pt(RD, 5'h01, 32'h0, 1'b0);
		tk(2);
		check("dq early", dq_out, 32'h0);
		check("dq drive", dq_oe, 1'b1);
		for (i = 0; i < 3; i++) begin
			tk(1);
			if (i == 0) pt(OEON, 5'h01, 32'h0, 1'b0);
			check("dq burst", dq_out, 32'ha000_0000 + i);
		end
		tk(2);
		check("dq held", dq_out, 32'ha000_0002);
		pt(SEL, 5'h01, 32'h0, 1'b0);
		tk(1);
		check("dq off", dq_oe, 1'b0);
	endtask
	// empty consumer is not ready; producer turns ready within 2..68 edges
	task automatic t_switch;
		int n;
		pt(SW, 5'h01, 32'h0, 1'b0);
		tk(1);
		pt(SEL, 5'h01, 32'h0, 1'b0);
		tk(8);
		check("ready consumer", trdy, 1'b0);
		pt(SW, 5'h00, 32'h0, 1'b0);
		tk(1);
		pt(SEL, 5'h00, 32'h0, 1'b0);
		check("ready early", trdy, 1'b0);
		for (n = 1; trdy !== 1'b1 && n < 68; n++) tk(1);
		check("ready late", trdy, 1'b1);
	endtask
	// strobe-timed mode with read strobe and enable tied together
	task automatic t_async;
		int i;
		async_m = 1'b1;
		b_mode = 2'h1;
		b_cur = 1'b1;
		for (i = 0; i < 2; i++) begin
			pt(WR, 5'h03, 32'hb000_0000 + i, 1'b1);
			wc(8);
			pt(SEL, 5'h03, 32'hb000_0000 + i, 1'b1);
			wc(8);
		end
		pt(PE, 5'h03, 32'h0, 1'b0);
		wc(8);
		pt(SEL, 5'h03, 32'h0, 1'b0);
		wc(8);
		for (i = 0; i < 2; i++) begin
			pt(RD, 5'h03, 32'h0, 1'b0);
			wc(8);
			check("async word", dq_out, 32'hb000_0000 + i);
			check("async drive", dq_oe, 1'b1);
			pt(SEL, 5'h03, 32'h0, 1'b0);
			wc(8);
		end
		a_mode = 2'h3;
		wc(8);
		check("flag off", fa, 1'b0);
		b_mode = 2'h0;
		wc(8);
		check("flag b empty", fb, 1'b1);
	endtask
	initial begin
		wc(10);
		nrst = 1'b1;
		wc(8);
		t_write;
		t_read;
		t_switch;
		t_async;
		finish_test;
	end
	// watchdog: the sequence needs well under 40 us
	initial begin
		#200000;
		err_total++;
		finish_test;
	end
endmodule // slave_fifo_port_tb
